// File: verilog/bac_pkg.sv
// Constants and carrier types for the bus area controller.
// Assumes a 20-bit CPU address and 8-bit register port data.
package bac_pkg;

  // ****************************************
  // Register port map
  // ****************************************
  localparam int BAC_REG_AW = 2;
  localparam logic [1:0] BAC_IDX_BYTE_AREA = 2'h0;
  localparam logic [1:0] BAC_IDX_THREE_STATE = 2'h1;
  localparam logic [1:0] BAC_IDX_BUS_CONTROL = 2'h2;

  // ****************************************
  // Bus control field positions
  // ****************************************
  localparam int BAC_BIT_BCE = 7;
  localparam int BAC_BIT_P0SO = 6;
  localparam int BAC_BIT_RSVD = 5;
  localparam int BAC_BIT_P9A = 4;
  localparam int BAC_BIT_EXP = 3;
  localparam int BAC_BIT_PUC = 2;
  localparam int BAC_BIT_PBC = 1;
  localparam int BAC_BIT_P12 = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] BAC_BYTE_AREA_RST = 8'hFF;
  localparam logic [7:0] BAC_THREE_MIN_RST = 8'hEE;
  localparam logic [7:0] BAC_THREE_MAX_RST = 8'h0E;
  localparam logic [4:0] BAC_PORT_BITS_RST = 5'h1F;
  localparam logic [2:0] BAC_MODE_RST = 3'h7;

  // ****************************************
  // Address map
  // ****************************************
  localparam logic [19:0] BAC_ROM0_TOP = 20'h03FFF;
  localparam logic [19:0] BAC_ROM1_BASE = 20'h10000;
  localparam logic [19:0] BAC_ROM1_TOP = 20'h2FFFF;
  localparam logic [15:0] BAC_RAM_BASE = 16'hEE80;
  localparam logic [15:0] BAC_RAM_TOP = 16'hFE7F;
  localparam logic [15:0] BAC_REGS_BASE = 16'hFE80;
  localparam logic [15:0] BAC_P12_BASE = 16'hFE80;
  localparam logic [15:0] BAC_P9A_BASE = 16'hFE90;
  localparam logic [15:0] BAC_PBC_BASE = 16'hFE94;
  localparam logic [15:0] BAC_PUC_BASE = 16'hFE98;
  localparam logic [15:0] BAC_EXP_BASE = 16'hFE9C;
  localparam logic [15:0] BAC_GROUP_MASK = 16'hFFFC;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    BAC_M1 = 3'h1,
    BAC_M2 = 3'h2,
    BAC_M3 = 3'h3,
    BAC_M4 = 3'h4,
    BAC_M5 = 3'h5,
    BAC_M6 = 3'h6,
    BAC_M7 = 3'h7
  } bac_mode_t;

  typedef struct packed {
    logic external;
    logic wide;
    logic three_state;
    logic upper_only;
    logic onchip;
  } bac_dec_t;

endpackage

// File: verilog/bac_core.sv
// Bus area controller: picks width and cycle length for every CPU access.
// Assumes mode pins are static straps and CPU requests come on ref_clk_i.
//
// Function
// - Page-zero override on makes every external page 0 access three-state.
// - In mode 7 the page-zero override has no effect.
// - Bus control bit 5 is read-only and always reads 1.
// - Port 9/A enable low sends its four addresses external, 8-bit, three-state.
// - Expanded-port bit low makes its four addresses external 8-bit three-state.
// - Pull-up control enable low sends its addresses external 8-bit three-state.
// - Port B/C enable low sends its four addresses external 8-bit three-state.
// - Port 1/2 enable low sends its four addresses external 8-bit three-state.
// - In mode 7 the port bits and expanded-port bit stay 1.
// - Mode 1 reset map: 16-bit two-state low, 16-bit three-state above EE00.
// - Enabled on-chip RAM is always 16-bit two-state.
// - Mode 2: ROM 16-bit two-state, external 8-bit three-state.
// - Mode 3 reset map: two-state below 0E000, three-state above.
// - Mode 4 reset map: ROM and low external two-state, higher three-state.
// - Mode 5 after reset: all external space 8-bit three-state on the upper byte.
// - Mode 6 after reset: external 8-bit three-state on the upper byte.
// - Mode 7 makes no external cycles; ROM is 16-bit two-state.
// - Boundary writes act from the very next bus cycle.
// - Bus control bits 4 to 0 rebuild lost ports off-chip.
// - Controller enable low forces every external access to 8-bit three-state.
// - Three-state boundary holds address bits 19:12 in modes 3 to 5, bits 15:8 otherwise; at or above is three-state.
`timescale 1ns/10ps

module bac_core
  import bac_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [2:0] mode_pins_i,
  input wire logic ram_enable_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [ADDR_W-1:0] acc_addr_i,
  input wire logic acc_req_i,
  output logic acc_valid_o,
  output bac_dec_t acc_dec_o,
  output logic ready_o
);

  // ****************************************
  // Elaboration check
  // ****************************************
  if (ADDR_W != 20) begin : g_bad_width
    $error("bac_core serves a 20-bit address only");
  end
  if (BAC_REG_AW != 2) begin : g_bad_index
    $error("bac_core decodes a 2-bit register index only");
  end
  // The read view packs the fields by position, so the package must keep that order.
  if (BAC_BIT_BCE != 7 || BAC_BIT_P0SO != 6 || BAC_BIT_RSVD != 5) begin : g_bad_upper
    $error("bac_core expects enable, override and reserved at bits 7 to 5");
  end
  if (BAC_BIT_P9A != 4 || BAC_BIT_EXP != 3 || BAC_BIT_PUC != 2 || BAC_BIT_PBC != 1 || BAC_BIT_P12 != 0) begin : g_bad_ports
    $error("bac_core expects the port group bits at 4 to 0");
  end

  // ****************************************
  // Mode strap capture
  // ****************************************
  // The strap cannot be loaded under reset, so it is caught after release.
  logic [2:0] mode_s1_reg;
  logic [2:0] mode_s2_reg;
  bac_mode_t mode_reg;
  bac_mode_t mode_next;
  logic [1:0] init_cnt_reg;
  logic ready_reg;
  wire init_step = !ready_reg && (init_cnt_reg == 2'h2);

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_s1_reg <= 3'h0;
    end else begin
      mode_s1_reg <= mode_pins_i;
    end
  end

  // Only this second stage may feed logic; the first one can still be settling.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_s2_reg <= 3'h0;
    end else begin
      mode_s2_reg <= mode_s1_reg;
    end
  end

  // ****************************************
  // Strap decode
  // ****************************************
  always_comb begin
    case (mode_s2_reg)
      3'h1: mode_next = BAC_M1;
      3'h2: mode_next = BAC_M2;
      3'h3: mode_next = BAC_M3;
      3'h4: mode_next = BAC_M4;
      3'h5: mode_next = BAC_M5;
      3'h6: mode_next = BAC_M6;
      default: mode_next = BAC_M7;
    endcase
  end

  // ****************************************
  // Start-up sequence
  // ****************************************
  wire [1:0] init_cnt_next = (!ready_reg && init_cnt_reg != 2'h2) ? init_cnt_reg + 2'h1 : init_cnt_reg;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      init_cnt_reg <= 2'h0;
    end else begin
      init_cnt_reg <= init_cnt_next;
    end
  end

  // The mode is taken once; a strap that moves later has no effect until the next reset.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_reg <= BAC_M7;
    end else if (init_step) begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_reg <= 1'b0;
    end else if (init_step) begin
      ready_reg <= 1'b1;
    end
  end

  // ****************************************
  // Mode decode
  // ****************************************
  wire is_m2 = (mode_reg == BAC_M2);
  wire is_m4 = (mode_reg == BAC_M4);
  wire is_m7 = (mode_reg == BAC_M7);
  wire is_m56 = (mode_reg == BAC_M5) || (mode_reg == BAC_M6);
  wire max_mode = (mode_reg == BAC_M3) || is_m4 || (mode_reg == BAC_M5);
  wire next_max = (mode_next == BAC_M3) || (mode_next == BAC_M4) || (mode_next == BAC_M5);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] byte_area_reg;
  logic [7:0] three_state_reg;
  logic bce_reg;
  logic p0so_reg;
  logic [4:0] port_bits_reg;

  // ****************************************
  // Register write decode
  // ****************************************
  wire wr_byte = reg_wr_i && (reg_addr_i == BAC_IDX_BYTE_AREA);
  wire wr_three = reg_wr_i && (reg_addr_i == BAC_IDX_THREE_STATE);
  wire wr_ctrl = reg_wr_i && (reg_addr_i == BAC_IDX_BUS_CONTROL);
  // Outside modes 5 and 6 the controller is always on and cannot be cleared.
  wire bce_eff = bce_reg || !is_m56;
  wire bce_next = wr_ctrl && is_m56 ? reg_wdata_i[BAC_BIT_BCE] : bce_reg;
  // Clears to port bits are dropped in mode 7.
  wire [4:0] port_bits_next = wr_ctrl ? (reg_wdata_i[4:0] | {5{is_m7}}) : port_bits_reg;
  wire [7:0] three_state_next = init_step ? (next_max ? BAC_THREE_MAX_RST : BAC_THREE_MIN_RST)
                                          : (wr_three ? reg_wdata_i : three_state_reg);
  // Bit 5 has no storage, so a write cannot change it.
  wire [7:0] ctrl_view = {bce_eff, p0so_reg, 1'b1, port_bits_reg};
  wire [7:0] rd_mux = (reg_addr_i == BAC_IDX_BYTE_AREA) ? byte_area_reg :
                      (reg_addr_i == BAC_IDX_THREE_STATE) ? three_state_reg :
                      (reg_addr_i == BAC_IDX_BUS_CONTROL) ? ctrl_view : 8'h00;
  wire [7:0] rdata_next = reg_rd_i ? rd_mux : 8'h00;
  wire [7:0] byte_area_next = wr_byte ? reg_wdata_i : byte_area_reg;
  wire p0so_next = wr_ctrl ? reg_wdata_i[BAC_BIT_P0SO] : p0so_reg;

  // ****************************************
  // Register storage
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      byte_area_reg <= BAC_BYTE_AREA_RST;
    end else begin
      byte_area_reg <= byte_area_next;
    end
  end

  // The mode reset value arrives with the start-up step and wins over a racing write.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      three_state_reg <= BAC_THREE_MIN_RST;
    end else begin
      three_state_reg <= three_state_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bce_reg <= 1'b0;
    end else begin
      bce_reg <= bce_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      p0so_reg <= 1'b0;
    end else begin
      p0so_reg <= p0so_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_bits_reg <= BAC_PORT_BITS_RST;
    end else begin
      port_bits_reg <= port_bits_next;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= rdata_next;
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  wire [15:0] low16 = acc_addr_i[15:0];
  wire [3:0] page = max_mode ? acc_addr_i[19:16] : 4'h0;
  wire page0 = (page == 4'h0);
  wire rom_lo = (acc_addr_i <= BAC_ROM0_TOP);
  wire rom_hi = (acc_addr_i >= BAC_ROM1_BASE) && (acc_addr_i <= BAC_ROM1_TOP);
  // Only modes 2, 4 and 7 have on-chip ROM in the map.
  wire rom_hit = (rom_lo && (is_m2 || is_m4 || is_m7)) || (rom_hi && (is_m4 || is_m7));
  wire ram_hit = ram_enable_i && page0 && (low16 >= BAC_RAM_BASE) && (low16 <= BAC_RAM_TOP);
  wire regs_hit = page0 && (low16 >= BAC_REGS_BASE);

  // ****************************************
  // Port groups
  // ****************************************
  // Each disabled port group turns its four addresses into external space.
  localparam logic [15:0] GROUP_BASE [5] = '{BAC_P12_BASE, BAC_PBC_BASE, BAC_PUC_BASE,
                                              BAC_EXP_BASE, BAC_P9A_BASE};
  // The group match masks two address bits, so every base must sit on a four-byte boundary.
  for (genvar c = 0; c < 5; c++) begin : g_base_check
    if (GROUP_BASE[c][1:0] != 2'h0) begin : g_bad_base
      $error("bac_core port group base is not aligned");
    end
  end
  logic [4:0] group_off;
  for (genvar g = 0; g < 5; g++) begin : g_port
    assign group_off[g] = page0 && ((low16 & BAC_GROUP_MASK) == GROUP_BASE[g])
                          && !port_bits_reg[g];
  end
  wire port_ext = |group_off;

  // ****************************************
  // Area selection
  // ****************************************
  wire [7:0] top8 = max_mode ? acc_addr_i[19:12] : acc_addr_i[15:8];
  wire over_three = (top8 >= three_state_reg);
  wire over_byte = (top8 > byte_area_reg);
  wire page0_slow = p0so_reg && page0 && !is_m7;
  wire ext_three = over_three || page0_slow || over_byte;
  wire ext_wide = !over_byte;
  wire is_onchip = ram_hit || rom_hit || (regs_hit && !port_ext);
  wire is_ext = !is_onchip && !is_m7;

  // ****************************************
  // Decision logic
  // ****************************************
  bac_dec_t dec_next;

  always_comb begin
    dec_next = '0;
    if (ram_hit || rom_hit) begin
      dec_next.onchip = 1'b1;
      dec_next.wide = 1'b1;
    end else if (regs_hit && !port_ext) begin
      dec_next.onchip = 1'b1;
      dec_next.three_state = 1'b1;
    end else if (is_ext) begin
      dec_next.external = 1'b1;
      if (port_ext) begin
        dec_next.three_state = 1'b1;
        dec_next.upper_only = !is_m2;
      end else if (!bce_eff) begin
        dec_next.three_state = 1'b1;
        dec_next.upper_only = 1'b1;
      end else if (is_m2) begin
        dec_next.three_state = 1'b1;
      end else begin
        dec_next.wide = ext_wide;
        dec_next.three_state = ext_three;
        dec_next.upper_only = !ext_wide;
      end
    end
  end

  // ****************************************
  // Decision output
  // ****************************************
  // Register writes land on the edge ending the write, so the next request sees them.
  // Taking requests only once ready_o shows high keeps every answer behind the visible ready.
  wire acc_take = acc_req_i && ready_o;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_valid_o <= 1'b0;
    end else begin
      acc_valid_o <= acc_take;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_dec_o <= '0;
    end else begin
      acc_dec_o <= acc_take ? dec_next : '0;
    end
  end

  // ****************************************
  // Readiness
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= ready_reg;
    end
  end

endmodule

// File: verif/bac_ext_mem.sv
// Far-side model: counts decoded bus cycles that leave the chip.
// Assumes one decode result per valid pulse on ref_clk_i.
`timescale 1ns/10ps
module bac_ext_mem
  import bac_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic acc_valid_i,
  input wire bac_dec_t acc_dec_i,
  output logic [7:0] ext_count_o
);
  // A count rather than a memory, because the decoder moves no data.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_count_o <= 8'h00;
    end else if (acc_valid_i && acc_dec_i.external) begin
      ext_count_o <= ext_count_o + 8'h01;
    end
  end
endmodule

// File: verif/bac_monitor.sv
// Port assertions for bac_core.
// Assumes the mode straps change only while reset is held.
`timescale 1ns/10ps
module bac_monitor
  import bac_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [2:0] mode_pins_i,
  input wire logic ram_enable_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [ADDR_W-1:0] acc_addr_i,
  input wire logic acc_req_i,
  input wire logic acc_valid_o,
  input wire bac_dec_t acc_dec_o,
  input wire logic ready_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic mode7 = (mode_pins_i == 3'h7) || (mode_pins_i == 3'h0);
  wire logic ram_hit = ram_enable_i && (acc_addr_i[15:0] >= BAC_RAM_BASE) && (acc_addr_i[15:0] <= BAC_RAM_TOP)
    && (acc_addr_i[ADDR_W-1:16] == '0);
  sequence s_take;
    acc_req_i && ready_o;
  endsequence
  sequence s_answer;
    acc_valid_o;
  endsequence
  a_req_answered: assert property (s_take |=> s_answer) else $error("request not answered");
  a_no_stray: assert property (!(acc_req_i && ready_o) |=> !acc_valid_o) else $error("valid without request");
  a_ram_fast: assert property (acc_req_i && ready_o && ram_hit |=> acc_dec_o.onchip && acc_dec_o.wide
    && !acc_dec_o.three_state) else $error("ram access not fast wide");
  a_mode7_internal: assert property (acc_valid_o && mode7 |-> !acc_dec_o.external)
    else $error("external cycle in mode 7");
  a_byte_slow: assert property (acc_valid_o && acc_dec_o.external && !acc_dec_o.wide |-> acc_dec_o.three_state)
    else $error("byte cycle not slow");
  a_reserved_one: assert property (reg_rd_i && reg_addr_i == BAC_IDX_BUS_CONTROL |=> reg_rdata_o[5])
    else $error("reserved bit read 0");
  a_mode7_ports: assert property (reg_rd_i && mode7 && reg_addr_i == BAC_IDX_BUS_CONTROL
    |=> reg_rdata_o[4:0] == 5'h1F) else $error("port bits cleared in mode 7");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 2'h3 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_quiet: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("read data outside slot");
  a_ready_holds: assert property (ready_o |=> ready_o) else $error("ready dropped");
endmodule

bind bac_core bac_monitor #(.ADDR_W(ADDR_W)) i_mon (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
  .mode_pins_i(mode_pins_i), .ram_enable_i(ram_enable_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .acc_addr_i(acc_addr_i),
  .acc_req_i(acc_req_i), .acc_valid_o(acc_valid_o), .acc_dec_o(acc_dec_o), .ready_o(ready_o));

// File: verif/bus_area_controller_test.sv
// Self-checking bench for bac_core.
// Assumes bac_monitor and bac_ext_mem are compiled beside it.
`timescale 1ns/10ps
module bus_area_controller_test;
  import bac_pkg::*;
  logic ref_clk_i = 0;
  logic reset_n_i = 0;
  logic [2:0] mode_pins_i = 3'h1;
  logic ram_enable_i = 1;
  logic [1:0] reg_addr_i = 0;
  logic [7:0] reg_wdata_i = 0;
  logic reg_wr_i = 0;
  logic reg_rd_i = 0;
  logic acc_req_i = 0;
  logic [19:0] acc_addr_i = 0;
  logic [7:0] reg_rdata_o;
  logic acc_valid_o;
  logic ready_o;
  logic rd_prev = 0;
  bac_dec_t acc_dec_o;
  logic [7:0] ext_count;
  logic [7:0] eq[$];
  logic [19:0] grp [5] = '{20'h0FE80, 20'h0FE90, 20'h0FE94, 20'h0FE98, 20'h0FE9C};
  int fails = 0;
  int n_tests = 0;
  bac_core i_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .mode_pins_i(mode_pins_i),
    .ram_enable_i(ram_enable_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .acc_addr_i(acc_addr_i), .acc_req_i(acc_req_i),
    .acc_valid_o(acc_valid_o), .acc_dec_o(acc_dec_o), .ready_o(ready_o));
  bac_ext_mem i_ext (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .acc_valid_i(acc_valid_o),
    .acc_dec_i(acc_dec_o), .ext_count_o(ext_count));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Every edge assigns every strobe once, so calls may follow with no gap.
  task automatic drive(input logic w, input logic r, input logic a, input logic [1:0] ix, input logic [19:0] ad,
    input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= w;
    reg_rd_i <= r;
    acc_req_i <= a;
    reg_addr_i <= ix;
    acc_addr_i <= ad;
    reg_wdata_i <= d;
  endtask
  task automatic wr(input logic [1:0] ix, input logic [7:0] d);
    drive(1'b1, 1'b0, 1'b0, ix, 20'h00000, d);
  endtask
  task automatic rd(input logic [1:0] ix, input logic [7:0] exp);
    eq.push_back(exp);
    drive(1'b0, 1'b1, 1'b0, ix, 20'h00000, 8'h00);
  endtask
  task automatic acc(input logic [19:0] ad, input logic [4:0] exp);
    eq.push_back({3'h0, exp});
    drive(1'b0, 1'b0, 1'b1, 2'h0, ad, 8'h00);
  endtask
  task automatic rst(input logic [2:0] m);
    drive(1'b0, 1'b0, 1'b0, 2'h0, 20'h00000, 8'h00);
    @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    mode_pins_i <= m;
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    // Requests during start-up must be refused, so none of them is queued.
    acc_req_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check({7'h00, ready_o}, 8'h00);
    @(posedge ref_clk_i);
    acc_req_i <= 1'b0;
    @(negedge ref_clk_i);
    check({7'h00, ready_o}, 8'h01);
    @(posedge ref_clk_i);
  endtask
  always @(negedge ref_clk_i) begin
    if (rd_prev === 1'b1 || acc_valid_o === 1'b1) begin
      if (eq.size() == 0) fails++;
      else check(rd_prev ? reg_rdata_o : {3'h0, acc_dec_o}, eq.pop_front());
    end
    rd_prev = reg_rd_i;
  end
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (2000) @(posedge ref_clk_i);
    fails++;
    print_verdict;
  end
  initial begin
    void'($urandom(42));
    rst(3'h1);
    rd(2'h0, 8'hFF);
    rd(2'h1, 8'hEE);
    rd(2'h2, 8'hBF);
    wr(2'h3, 8'($urandom));
    rd(2'h3, 8'h00);
    acc(20'h0EDFF, 5'h18);
    acc(20'h0EE00, 5'h1C);
    acc(20'h0EE80, 5'h09);
    acc(20'h0FE80, 5'h05);
    wr(2'h2, 8'h5F);
    rd(2'h2, 8'hFF);
    acc(20'h01000, 5'h1C);
    wr(2'h2, 8'h00);
    rd(2'h2, 8'hA0);
    acc(20'h01000, 5'h18);
    foreach (grp[i]) acc(grp[i], 5'h16);
    acc(20'h0FEA0, 5'h05);
    wr(2'h1, 8'h10);
    acc(20'h01000, 5'h1C);
    acc(20'h00FFF, 5'h18);
    wr(2'h0, 8'h0F);
    acc(20'h01000, 5'h16);
    ram_enable_i <= 0;
    acc(20'h0EE80, 5'h16);
    rst(3'h2);
    acc(20'h00000, 5'h09);
    acc(20'h04000, 5'h14);
    rst(3'h3);
    rd(2'h1, 8'h0E);
    acc(20'h0DFFF, 5'h18);
    acc(20'h10000, 5'h1C);
    rst(3'h4);
    acc(20'h10000, 5'h09);
    acc(20'h04000, 5'h18);
    acc(20'h30000, 5'h1C);
    rst(3'h5);
    rd(2'h2, 8'h3F);
    acc(20'hFFFFF, 5'h16);
    wr(2'h2, 8'h9F);
    acc(20'h00000, 5'h18);
    rst(3'h6);
    acc(20'h00000, 5'h16);
    rst(3'h7);
    wr(2'h2, 8'h40);
    rd(2'h2, 8'hFF);
    acc(20'h05000, 5'h00);
    acc(20'h0FE80, 5'h05);
    acc(20'h20000, 5'h09);
    acc(20'($urandom) & 20'h03FFF, 5'h09);
    drive(1'b0, 1'b0, 1'b0, 2'h0, 20'h00000, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    check(ext_count, 8'h00);
    check(8'(eq.size()), 8'h00);
    print_verdict;
  end
endmodule
